// >>> clock_divider_pkg.sv
// Purpose: Shared constants for the audio clock divider configuration block
// Assumes: 8-bit register map on the device control port
// Notes:   Write masks keep read-only reserved bits at their reset values
package clock_divider_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] SEC_LOW_ADDR    = 8'h3D;
  localparam logic [7:0] ANA_ADDR        = 8'h3E;
  localparam logic [7:0] CORE_EN_ADDR    = 8'h44;
  localparam logic [7:0] IF_EN_ADDR      = 8'h45;
  localparam logic [7:0] CLKOUT1_ADDR    = 8'h46;

  localparam logic [7:0] SEC_LOW_RESET   = 8'h01;
  localparam logic [7:0] ANA_RESET       = 8'h01;
  localparam logic [7:0] CORE_EN_RESET   = 8'h00;
  localparam logic [7:0] IF_EN_RESET     = 8'h00;
  localparam logic [7:0] CLKOUT1_RESET   = 8'h00;

  // Writable bits of each register; the rest read back as zero
  localparam logic [7:0] SEC_LOW_MASK    = 8'hFF;
  localparam logic [7:0] ANA_MASK        = 8'h3F;
  localparam logic [7:0] CORE_EN_MASK    = 8'h07;
  localparam logic [7:0] IF_EN_MASK      = 8'hFF;
  localparam logic [7:0] CLKOUT1_MASK    = 8'h07;
  localparam logic [7:0] READ_ZERO       = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int N_EN_BIT     = 2;
  localparam int M_EN_BIT     = 1;
  localparam int PDM_EN_BIT   = 0;
  localparam int DAC_EN_BIT   = 4;
  localparam int PRI_BCLK_BIT = 3;
  localparam int SEC_BCLK_BIT = 2;
  localparam int PRI_FS_BIT   = 1;
  localparam int SEC_FS_BIT   = 0;

  // ==========================================================================
  // Ratio encodings
  typedef logic [9:0] sec_ratio_type;
  typedef logic [6:0] ana_ratio_type;
  typedef logic [8:0] sec_code_type;

  localparam sec_code_type  SEC_CODE_ZERO    = 9'h000;
  localparam sec_code_type  SEC_CODE_ODD     = 9'h03F;
  localparam sec_ratio_type SEC_ZERO_RATIO   = 10'h200;
  localparam sec_ratio_type SEC_ODD_RATIO    = 10'h1FF;
  localparam logic [5:0]    ANA_CODE_ZERO    = 6'h00;
  localparam ana_ratio_type ANA_ZERO_RATIO   = 7'h40;
  localparam sec_ratio_type COUNT_ONE        = 10'h001;
  localparam sec_ratio_type COUNT_ZERO       = 10'h000;
  localparam logic [2:0]    ANA_PAD          = 3'h0;

endpackage

// >>> audio_clock_divider_config.sv
// Purpose: Divider value and enable registers with two live divided clocks
// Assumes: Control port strobes are synchronous to clock, one cycle each
// Notes:   A ratio of one cannot toggle a flop clock; output then stays high
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Secondary bit-clock code zero means divide by 512.
// - Secondary codes 1 to 62 divide by the code itself.
// - Secondary code 63 divides by 511.
// - Auto clock detection overrides programmed ratios with derived ones.
// - Analog divider code zero means divide by 64.
// - Analog divider codes 1 to 63 divide by the code itself.
// - N, M and PDM enables follow bits 2, 1, 0; the analog N-M clock runs on bit 2 alone.
// - DAC modulator divider runs only while interface enable bit 4 set.
// - Primary bit-clock divider runs only while interface bit 3 set.
// - Secondary bit-clock divider runs only while interface bit 2 set.
// - Primary frame-sync divider runs only while interface bit 1 set.
// - Secondary frame-sync divider runs only while interface bit 0 set.
// - A separate high bit extends the secondary code above the low byte.
module audio_clock_divider_config
(
  input  wire logic                          clock,          // 25 MHz
  input  wire logic                          reset,          // Sync, high
  input  wire logic                          clock_enable,   // Freeze when low
  input  wire logic                          write_strobe,   // Reg write
  input  wire logic                          read_strobe,    // Reg read
  input  wire logic [7:0]                    address,        // Reg address
  input  wire logic [7:0]                    write_data,     // Write byte
  output      logic [7:0]                    read_data,      // Read byte
  output      logic                          read_valid,     // Read done
  input  wire logic                          auto_detect_enable, // Auto
  input  wire clock_divider_pkg::sec_ratio_type auto_secondary_ratio, // Auto
  input  wire clock_divider_pkg::ana_ratio_type auto_analog_ratio, // Auto
  input  wire logic                          secondary_bitclk_divider_high,
  output      logic                          n_divider_enable,    // N div
  output      logic                          m_divider_enable,    // M div
  output      logic                          pdm_clock_divider_enable,
  output      logic                          dac_modulator_divider_enable,
  output      logic                          primary_bitclk_divider_enable,
  output      logic                          secondary_bitclk_divider_enable,
  output      logic                          primary_frame_sync_divider_enable,
  output      logic                          secondary_frame_sync_divider_enable,
  output      clock_divider_pkg::sec_ratio_type secondary_bitclk_ratio,
  output      clock_divider_pkg::ana_ratio_type analog_clock_ratio,
  output      logic                          secondary_bitclk_out, // Divided
  output      logic                          analog_clock_out      // Divided
);
  import clock_divider_pkg::*;

  // ==========================================================================
  // Registers
  logic [7:0]    sec_low_q;
  logic [7:0]    ana_q;
  logic [7:0]    core_en_q;
  logic [7:0]    if_en_q;
  logic [7:0]    clkout1_q;
  logic [7:0]    read_data_q;
  logic          read_valid_q;
  sec_ratio_type sec_ratio_q;
  ana_ratio_type ana_ratio_q;
  sec_ratio_type sec_count_q;
  sec_ratio_type ana_count_q;
  logic          sec_clk_q;
  logic          ana_clk_q;
  sec_code_type  sec_code;
  logic          write_now;

  assign write_now = clock_enable && write_strobe;
  assign sec_code  = {secondary_bitclk_divider_high, sec_low_q};

  function automatic sec_ratio_type sec_decode(input sec_code_type code);
    if (code == SEC_CODE_ZERO)
      sec_decode = SEC_ZERO_RATIO;
    else if (code == SEC_CODE_ODD)
      sec_decode = SEC_ODD_RATIO;
    else
      sec_decode = {1'b0, code};
  endfunction

  function automatic sec_ratio_type count_step(input sec_ratio_type count,
                                               input sec_ratio_type ratio);
    if (count >= ratio - COUNT_ONE)
      count_step = COUNT_ZERO;
    else
      count_step = count + COUNT_ONE;
  endfunction

  // High for the first half of each period, rounded up; halving before
  // adding the odd bit keeps the largest auto ratio from wrapping to zero
  function automatic logic clock_level(input sec_ratio_type count,
                                       input sec_ratio_type ratio);
    clock_level = count < ((ratio >> 1) + sec_ratio_type'(ratio[0]));
  endfunction

  // ==========================================================================
  // Register writes; masks keep read-only reserved bits at reset value
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sec_low_q <= SEC_LOW_RESET;
      ana_q     <= ANA_RESET;
      core_en_q <= CORE_EN_RESET;
      if_en_q   <= IF_EN_RESET;
      clkout1_q <= CLKOUT1_RESET;
    end
    else if (write_now)
    begin
      case (address)
        SEC_LOW_ADDR: sec_low_q <= write_data & SEC_LOW_MASK;
        ANA_ADDR:     ana_q     <= write_data & ANA_MASK;
        CORE_EN_ADDR: core_en_q <= write_data & CORE_EN_MASK;
        IF_EN_ADDR:   if_en_q   <= write_data & IF_EN_MASK;
        CLKOUT1_ADDR: clkout1_q <= write_data & CLKOUT1_MASK;
        default:      ;
      endcase
    end
  end

  // ==========================================================================
  // Register reads; unmapped addresses return zero
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      read_data_q  <= READ_ZERO;
      read_valid_q <= 1'b0;
    end
    else if (clock_enable)
    begin
      read_valid_q <= read_strobe;
      if (read_strobe)
      begin
        case (address)
          SEC_LOW_ADDR: read_data_q <= sec_low_q;
          ANA_ADDR:     read_data_q <= ana_q;
          CORE_EN_ADDR: read_data_q <= core_en_q;
          IF_EN_ADDR:   read_data_q <= if_en_q;
          CLKOUT1_ADDR: read_data_q <= clkout1_q;
          default:      read_data_q <= READ_ZERO;
        endcase
      end
    end
  end

  // ==========================================================================
  // Effective ratios
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sec_ratio_q <= sec_decode({1'b0, SEC_LOW_RESET});
      ana_ratio_q <= {1'b0, ANA_RESET[5:0]};
    end
    else if (clock_enable)
    begin
      if (auto_detect_enable)
      begin
        sec_ratio_q <= auto_secondary_ratio;
        ana_ratio_q <= auto_analog_ratio;
      end
      else
      begin
        sec_ratio_q <= sec_decode(sec_code);
        if (ana_q[5:0] == ANA_CODE_ZERO)
          ana_ratio_q <= ANA_ZERO_RATIO;
        else
          ana_ratio_q <= {1'b0, ana_q[5:0]};
      end
    end
  end

  // ==========================================================================
  // Divided clocks; restarting from count zero gives a clean first high phase
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sec_count_q <= COUNT_ZERO;
      sec_clk_q   <= 1'b0;
    end
    else if (clock_enable)
    begin
      if (!if_en_q[SEC_BCLK_BIT])
      begin
        sec_count_q <= COUNT_ZERO;
        sec_clk_q   <= 1'b0;
      end
      else
      begin
        sec_count_q <= count_step(sec_count_q, sec_ratio_q);
        sec_clk_q   <= clock_level(sec_count_q, sec_ratio_q);
      end
    end
  end

  // The analog N-M path is gated by the N divider enable
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ana_count_q <= COUNT_ZERO;
      ana_clk_q   <= 1'b0;
    end
    else if (clock_enable)
    begin
      if (!core_en_q[N_EN_BIT])
      begin
        ana_count_q <= COUNT_ZERO;
        ana_clk_q   <= 1'b0;
      end
      else
      begin
        ana_count_q <= count_step(ana_count_q, {ANA_PAD, ana_ratio_q});
        ana_clk_q   <= clock_level(ana_count_q, {ANA_PAD, ana_ratio_q});
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign read_data                          = read_data_q;
  assign read_valid                         = read_valid_q;
  assign n_divider_enable                   = core_en_q[N_EN_BIT];
  assign m_divider_enable                   = core_en_q[M_EN_BIT];
  assign pdm_clock_divider_enable           = core_en_q[PDM_EN_BIT];
  assign dac_modulator_divider_enable       = if_en_q[DAC_EN_BIT];
  assign primary_bitclk_divider_enable      = if_en_q[PRI_BCLK_BIT];
  assign secondary_bitclk_divider_enable    = if_en_q[SEC_BCLK_BIT];
  assign primary_frame_sync_divider_enable  = if_en_q[PRI_FS_BIT];
  assign secondary_frame_sync_divider_enable = if_en_q[SEC_FS_BIT];
  assign secondary_bitclk_ratio             = sec_ratio_q;
  assign analog_clock_ratio                 = ana_ratio_q;
  assign secondary_bitclk_out               = sec_clk_q;
  assign analog_clock_out                   = ana_clk_q;

  // ==========================================================================
  // Assertions
  sec_zero_ratio_a: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable && !auto_detect_enable && sec_code == SEC_CODE_ZERO
    |=> secondary_bitclk_ratio == SEC_ZERO_RATIO)
    else $error("secondary code zero did not give 512");

  sec_direct_ratio_a: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable && !auto_detect_enable && sec_code > SEC_CODE_ZERO
    && sec_code < SEC_CODE_ODD
    |=> secondary_bitclk_ratio == {1'b0, $past(sec_code)})
    else $error("secondary code not used directly");

  sec_odd_ratio_a: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable && !auto_detect_enable && sec_code == SEC_CODE_ODD
    |=> secondary_bitclk_ratio == SEC_ODD_RATIO)
    else $error("secondary code 63 did not give 511");

  auto_override_a: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable && auto_detect_enable
    |=> secondary_bitclk_ratio == $past(auto_secondary_ratio)
    && analog_clock_ratio == $past(auto_analog_ratio))
    else $error("auto detection did not override ratios");

  ana_zero_ratio_a: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable && !auto_detect_enable && ana_q[5:0] == ANA_CODE_ZERO
    |=> analog_clock_ratio == ANA_ZERO_RATIO)
    else $error("analog code zero did not give 64");

  ana_direct_ratio_a: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable && !auto_detect_enable && ana_q[5:0] != ANA_CODE_ZERO
    |=> analog_clock_ratio == {1'b0, $past(ana_q[5:0])})
    else $error("analog code not used directly");

  core_enable_a: assert property (
    @(posedge clock) disable iff (reset)
    write_now && address == CORE_EN_ADDR
    |=> {n_divider_enable, m_divider_enable, pdm_clock_divider_enable}
    == $past(write_data[2:0]) && core_en_q[7:3] == 5'h00)
    else $error("core divider enables not taken from write");

  dac_enable_a: assert property (
    @(posedge clock) disable iff (reset)
    write_now && address == IF_EN_ADDR
    |=> dac_modulator_divider_enable == $past(write_data[4]))
    else $error("dac modulator enable not taken");

  pri_bclk_enable_a: assert property (
    @(posedge clock) disable iff (reset)
    write_now && address == IF_EN_ADDR
    |=> primary_bitclk_divider_enable == $past(write_data[3]))
    else $error("primary bit clock enable not taken");

  sec_bclk_enable_a: assert property (
    @(posedge clock) disable iff (reset)
    write_now && address == IF_EN_ADDR
    |=> secondary_bitclk_divider_enable == $past(write_data[2]))
    else $error("secondary bit clock enable not taken");

  pri_fs_enable_a: assert property (
    @(posedge clock) disable iff (reset)
    write_now && address == IF_EN_ADDR
    |=> primary_frame_sync_divider_enable == $past(write_data[1]))
    else $error("primary frame sync enable not taken");

  sec_fs_enable_a: assert property (
    @(posedge clock) disable iff (reset)
    write_now && address == IF_EN_ADDR
    |=> secondary_frame_sync_divider_enable == $past(write_data[0]))
    else $error("secondary frame sync enable not taken");

  sec_high_bit_a: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable && !auto_detect_enable && secondary_bitclk_divider_high
    |=> secondary_bitclk_ratio == {1'b0, 1'b1, $past(sec_low_q)})
    else $error("secondary high bit not concatenated");

  sec_static_off_a: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable && !secondary_bitclk_divider_enable
    |=> !secondary_bitclk_out)
    else $error("disabled secondary divider not static");

  sec_restart_a: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable && $rose(secondary_bitclk_divider_enable)
    |=> secondary_bitclk_out)
    else $error("enabled secondary divider did not start high");

endmodule
`default_nettype wire

// >>> audio_clock_divider_config_bench.sv
// Purpose: Self-checking bench for the audio clock divider configuration
// Assumes: Inputs change on the falling edge; one register access per task
// Notes:   Ratio rows run in a loop; refusals and divided clocks follow
`timescale 1ns/10ps
`default_nettype none
module audio_clock_divider_config_bench;
  import clock_divider_pkg::*;

  // ==========================================================================
  // Stimulus and observed signals
  logic          clock                = 1'b0;
  logic          reset                = 1'b1;
  logic          clock_enable         = 1'b1;
  logic          write_strobe         = 1'b0;
  logic          read_strobe          = 1'b0;
  logic [7:0]    address              = 8'h00;
  logic [7:0]    write_data           = 8'h00;
  logic          auto_detect_enable   = 1'b0;
  sec_ratio_type auto_secondary_ratio = 10'h000;
  ana_ratio_type auto_analog_ratio    = 7'h00;
  logic          sec_high             = 1'b0;
  logic [7:0]    read_data;
  logic          read_valid;
  logic [2:0]    core_en;
  logic [4:0]    if_en;
  sec_ratio_type secondary_bitclk_ratio;
  ana_ratio_type analog_clock_ratio;
  logic          secondary_bitclk_out;
  logic          analog_clock_out;
  int            error_cnt            = 0;
  int            n_compared           = 0;
  int            cycles               = 0;
  int            s_hi;
  int            a_hi;

  typedef struct {
    logic       hi;
    logic [7:0] sec_code;
    logic [9:0] sec_exp;
    logic [7:0] ana_code;
    logic [6:0] ana_exp;
  } row_type;

  // Codes with the ratio each must give; the 0xFF analog write probes
  // the read-only reserved bits
  row_type rows [8] = '{
    '{1'b0, 8'h00, 10'h200, 8'h00, 7'h40},
    '{1'b0, 8'h01, 10'h001, 8'h01, 7'h01},
    '{1'b0, 8'h02, 10'h002, 8'h02, 7'h02},
    '{1'b0, 8'h3E, 10'h03E, 8'h3E, 7'h3E},
    '{1'b0, 8'h3F, 10'h1FF, 8'h3F, 7'h3F},
    '{1'b1, 8'h05, 10'h105, 8'hFF, 7'h3F},
    '{1'b0, 8'h80, 10'h080, 8'h20, 7'h20},
    '{1'b1, 8'h00, 10'h100, 8'h07, 7'h07}};
  logic [7:0] reg_addr [5] = '{8'h3D, 8'h3E, 8'h44, 8'h45, 8'h46};
  logic [7:0] reg_rst  [5] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00};

  audio_clock_divider_config i_audio_clock_divider_config (
    .clock                               (clock),
    .reset                               (reset),
    .clock_enable                        (clock_enable),
    .write_strobe                        (write_strobe),
    .read_strobe                         (read_strobe),
    .address                             (address),
    .write_data                          (write_data),
    .read_data                           (read_data),
    .read_valid                          (read_valid),
    .auto_detect_enable                  (auto_detect_enable),
    .auto_secondary_ratio                (auto_secondary_ratio),
    .auto_analog_ratio                   (auto_analog_ratio),
    .secondary_bitclk_divider_high       (sec_high),
    .n_divider_enable                    (core_en[2]),
    .m_divider_enable                    (core_en[1]),
    .pdm_clock_divider_enable            (core_en[0]),
    .dac_modulator_divider_enable        (if_en[4]),
    .primary_bitclk_divider_enable       (if_en[3]),
    .secondary_bitclk_divider_enable     (if_en[2]),
    .primary_frame_sync_divider_enable   (if_en[1]),
    .secondary_frame_sync_divider_enable (if_en[0]),
    .secondary_bitclk_ratio              (secondary_bitclk_ratio),
    .analog_clock_ratio                  (analog_clock_ratio),
    .secondary_bitclk_out                (secondary_bitclk_out),
    .analog_clock_out                    (analog_clock_out));

  always #20 clock = ~clock;

  // ==========================================================================
  // Shared tasks
  task automatic close_out();
    $display("compares %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    write_strobe = 1'b1;
    address = a;
    write_data = d;
    @(negedge clock);
    write_strobe = 1'b0;
    // Idle cycle so a following call never re-raises the strobe at once
    @(negedge clock);
  endtask

  // Data is looked at in the one cycle that read_valid stands
  task automatic read_reg(input logic [7:0] a, input logic [7:0] exp);
    read_strobe = 1'b1;
    address = a;
    @(negedge clock);
    read_strobe = 1'b0;
    check(10'(read_valid), 10'h001);
    check(10'(read_data), 10'(exp));
    @(negedge clock);
  endtask

  task automatic sample8();
    s_hi = 0;
    a_hi = 0;
    repeat (8)
    begin
      @(negedge clock);
      s_hi += (secondary_bitclk_out === 1'b1);
      a_hi += (analog_clock_out === 1'b1);
    end
  endtask

  // Whole run needs well under 600 cycles
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      error_cnt++;
      close_out();
    end
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (8) @(negedge clock);
    reset = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      sec_high = rows[i].hi;
      write_reg(SEC_LOW_ADDR, rows[i].sec_code);
      write_reg(ANA_ADDR, rows[i].ana_code);
      @(negedge clock);
      check(secondary_bitclk_ratio, rows[i].sec_exp);
      check(10'(analog_clock_ratio), 10'(rows[i].ana_exp));
      read_reg(ANA_ADDR, {2'b00, rows[i].ana_code[5:0]});
    end
    $display("test done: ratio rows");
    for (int b = 0; b < 5; b++)
    begin
      write_reg(IF_EN_ADDR, 8'h01 << b);
      check(10'(if_en), 10'h001 << b);
    end
    for (int b = 0; b < 3; b++)
    begin
      write_reg(CORE_EN_ADDR, 8'h01 << b);
      check(10'(core_en), 10'h001 << b);
    end
    $display("test done: enable bits");
    // Hand-written: reset values, refusals, auto ratios, divided clocks
    reset = 1'b1;
    sec_high = 1'b0;
    @(negedge clock);
    reset = 1'b0;
    for (int i = 0; i < 5; i++)
      read_reg(reg_addr[i], reg_rst[i]);
    check(10'(core_en), 10'h000);
    check(secondary_bitclk_ratio, 10'h001);
    read_reg(8'h47, 8'h00);
    write_reg(CORE_EN_ADDR, 8'hFF);
    read_reg(CORE_EN_ADDR, 8'h07);
    write_reg(CLKOUT1_ADDR, 8'hFF);
    read_reg(CLKOUT1_ADDR, 8'h07);
    write_reg(IF_EN_ADDR, 8'hFF);
    read_reg(IF_EN_ADDR, 8'hFF);
    clock_enable = 1'b0;
    write_reg(IF_EN_ADDR, 8'h00);
    clock_enable = 1'b1;
    @(negedge clock);
    check(10'(if_en), 10'h01F);
    $display("test done: reset and refusals");
    auto_detect_enable = 1'b1;
    auto_secondary_ratio = 10'h2AA;
    auto_analog_ratio = 7'h55;
    @(negedge clock);
    check(secondary_bitclk_ratio, 10'h2AA);
    check(10'(analog_clock_ratio), 10'h055);
    auto_detect_enable = 1'b0;
    $display("test done: auto ratios");
    write_reg(SEC_LOW_ADDR, 8'h04);
    write_reg(ANA_ADDR, 8'h02);
    write_reg(IF_EN_ADDR, 8'h00);
    write_reg(CORE_EN_ADDR, 8'h00);
    sample8();
    check(10'(s_hi), 10'h000);
    check(10'(a_hi), 10'h000);
    write_reg(IF_EN_ADDR, 8'h04);
    // Write lands on one edge; the first enabled edge follows at once
    check(10'(secondary_bitclk_out), 10'h001);
    write_reg(CORE_EN_ADDR, 8'h04);
    sample8();
    check(10'(s_hi), 10'h004);
    check(10'(a_hi), 10'h004);
    write_reg(IF_EN_ADDR, 8'h00);
    @(negedge clock);
    check(10'(secondary_bitclk_out), 10'h000);
    $display("test done: divided clocks");
    close_out();
  end
endmodule
`default_nettype wire
